// ===== src/ufm_flow_multidrop.sv
// rx fifo plus xon/xoff flow control, special char, auto direction, multidrop
// assumes rx shifter, tx shifter, bitTick and charTick all on ref_clk
//
// What this block does
// - with software flow on, compare one or two rx chars to resume/stop
// - stop match halts transmit after the character now shifting ends
// - stop match with enable bit sets stop flag and raises interrupt
// - while suspended, resume match restarts transmit and clears flag
// - reset clears the four flow character registers to zero
// - pair mode needs two consecutive chars matching both programmed values
// - recognised flow chars are never pushed into the rx fifo
// - fifo at trigger: send stop chars one to two character times later
// - trigger levels 1,4,8,14; resume chars sent at 0,1,4,8
// - special mode: second stop char match is stored and sets flag
// - comparisons use only the selected 5 to 8 bit word length
// - auto direction: drive direction low after turn delay past last stop
// - auto direction: drive direction high before sending new data
// - auto direction: tx empty means shift register empty
// - normal multidrop: multidrop on, special off, forced parity zero
// - disabled receiver drops data, stores address with parity error
// - enabled receiver takes data, line status event per address
// - auto address: slave address lives in second stop char
// - auto address, unmatched: drop data and foreign addresses
// - matching address enables receiver, stored with parity flag, event
// - enabled: foreign address disables and drops; match is stored
// - select rts or dtr pin as direction output
`timescale 1ns/1ps

module ufm_fifo #(
  parameter int W = 9,
  parameter int D = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData,
  // fill level
  output logic [$clog2(D+1)-1:0] count
);
  localparam int AW = $clog2(D);
  localparam logic [AW-1:0] LAST = AW'(D - 1);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [$clog2(D+1)-1:0] cnt_q;
  logic push;
  logic pop;

  assign inReady = (cnt_q != ($clog2(D+1))'(D));
  assign outValid = (cnt_q != '0);
  assign outData = mem[rdPtr_q];
  assign count = cnt_q;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == LAST) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == LAST) ? '0 : rdPtr_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : ufm_fifo

module ufm_flow_multidrop #(
  parameter int DEPTH = ufm_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // configuration
  input wire ufm_pkg::ufm_cfg_s cfg,
  input wire logic charWrEn,
  input wire ufm_pkg::ufm_charsel_e charWrSel,
  input wire logic [7:0] charWrData,
  input wire logic isrRead,
  input wire logic lsrRead,
  // baud ticks
  input wire logic bitTick,
  input wire logic charTick,
  // rx shifter
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic rxParity,
  output logic rxReady,
  // rx fifo drain
  output logic rdValid,
  input wire logic rdReady,
  output ufm_pkg::ufm_rxword_s rdWord,
  // host tx data
  input wire logic txInValid,
  output logic txInReady,
  input wire logic [7:0] txInData,
  // tx shifter
  output logic txShValid,
  input wire logic txShReady,
  output logic [7:0] txShData,
  input wire logic txShBusy,
  input wire logic txShDone,
  // status and pins
  output logic stopFlag,
  output logic lineStatIrq,
  output logic irq,
  output logic rxTrigIrq,
  output logic txEmptyIrq,
  output logic rtsN,
  output logic dtrN
);

  // ****************************************
  // character registers
  // ****************************************
  logic [7:0] resume1_q;
  logic [7:0] resume2_q;
  logic [7:0] stop1_q;
  logic [7:0] stop2_q;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      resume1_q <= ufm_pkg::CHAR_RST;
      resume2_q <= ufm_pkg::CHAR_RST;
      stop1_q <= ufm_pkg::CHAR_RST;
      stop2_q <= ufm_pkg::CHAR_RST;
    end else if (charWrEn) begin
      case (charWrSel)
        ufm_pkg::CH_RESUME1: resume1_q <= charWrData;
        ufm_pkg::CH_RESUME2: resume2_q <= charWrData;
        ufm_pkg::CH_STOP1: stop1_q <= charWrData;
        default: stop2_q <= charWrData;
      endcase
    end
  end

  // ****************************************
  // rx comparison
  // ****************************************
  logic [7:0] mask;
  always_comb begin
    case (cfg.wordLen)
      2'h0: mask = ufm_pkg::MASK_5B;
      2'h1: mask = ufm_pkg::MASK_6B;
      2'h2: mask = ufm_pkg::MASK_7B;
      default: mask = ufm_pkg::MASK_8B;
    endcase
  end

  logic mOn1, mOn2, mOff1, mOff2;
  assign mOn1 = (((rxData ^ resume1_q) & mask) == 8'h00);
  assign mOn2 = (((rxData ^ resume2_q) & mask) == 8'h00);
  assign mOff1 = (((rxData ^ stop1_q) & mask) == 8'h00);
  assign mOff2 = (((rxData ^ stop2_q) & mask) == 8'h00);

  logic mdNormal, mdAuto, flowOn, pairMode;
  assign mdNormal = cfg.multidropEn && !cfg.specialEn;
  assign mdAuto = cfg.multidropEn && cfg.specialEn;
  assign flowOn = (cfg.rxFlow != ufm_pkg::FLOW_OFF) && !cfg.multidropEn;
  assign pairMode = (cfg.rxFlow == ufm_pkg::FLOW_PAIR);

  logic pendOn_q, pendOff_q;
  logic [7:0] pendData_q;
  logic carry_q;
  logic [7:0] carryData_q;
  logic stopHit, resumeHit, firstHit, flowHit, specialHit;

  always_comb begin
    stopHit = 1'b0;
    resumeHit = 1'b0;
    firstHit = 1'b0;
    if (rxValid && flowOn) begin
      case (cfg.rxFlow)
        ufm_pkg::FLOW_SET1: begin
          stopHit = mOff1;
          resumeHit = mOn1;
        end
        ufm_pkg::FLOW_SET2: begin
          stopHit = mOff2;
          resumeHit = mOn2;
        end
        default: begin
          stopHit = pendOff_q && mOff2;
          resumeHit = pendOn_q && mOn2;
          firstHit = !(stopHit || resumeHit) && (mOff1 || mOn1);
        end
      endcase
    end
  end

  assign flowHit = stopHit || resumeHit || firstHit;
  assign specialHit = rxValid && cfg.specialEn && !cfg.multidropEn && mOff2;

  // pair mode: first half held back until second decides its fate
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pendOn_q <= 1'b0;
      pendOff_q <= 1'b0;
      pendData_q <= 8'h00;
      carry_q <= 1'b0;
      carryData_q <= 8'h00;
    end else begin
      carry_q <= 1'b0;
      if (rxValid && flowOn && pairMode) begin
        pendOn_q <= firstHit && mOn1;
        pendOff_q <= firstHit && mOff1;
        pendData_q <= rxData;
        carry_q <= (pendOn_q || pendOff_q) && !flowHit;
        carryData_q <= rxData;
      end else if (!pairMode || !flowOn) begin
        pendOn_q <= 1'b0;
        pendOff_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // store decision and multidrop
  // ****************************************
  logic autoEn_q;
  logic keep, keepPe, lsrEv, addrHit;
  logic pushValid;
  ufm_pkg::ufm_rxword_s pushWord;

  assign addrHit = rxParity && mOff2;

  always_comb begin
    keep = 1'b1;
    keepPe = 1'b0;
    lsrEv = 1'b0;
    if (mdNormal) begin
      keep = rxParity || cfg.rxEnableSw;
      keepPe = rxParity;
      lsrEv = rxParity;
    end else if (mdAuto) begin
      if (rxParity) begin
        keep = addrHit;
        keepPe = 1'b1;
        lsrEv = addrHit;
      end else begin
        keep = autoEn_q;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      autoEn_q <= 1'b0;
    end else if (!mdAuto) begin
      autoEn_q <= 1'b0;
    end else if (rxValid && rxParity) begin
      autoEn_q <= addrHit;
    end
  end

  always_comb begin
    pushValid = 1'b0;
    pushWord = '0;
    if (carry_q) begin
      pushValid = 1'b1;
      pushWord.data = carryData_q;
    end else if (rxValid && flowOn && pairMode && (pendOn_q || pendOff_q) && !flowHit) begin
      pushValid = 1'b1;
      pushWord.data = pendData_q;
    end else if (rxValid && !flowHit && keep) begin
      pushValid = 1'b1;
      pushWord.pe = keepPe;
      pushWord.data = rxData;
    end
  end

  logic [ufm_pkg::FIFO_CNT_W-1:0] level;
  logic [$clog2(DEPTH+1)-1:0] fifoCnt;

  ufm_fifo #(.W(ufm_pkg::RXWORD_W), .D(DEPTH)) rxFifo (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .inValid(pushValid),
    .inReady(rxReady),
    .inData(pushWord),
    .outValid(rdValid),
    .outReady(rdReady),
    .outData(rdWord),
    .count(fifoCnt)
  );
  assign level = ufm_pkg::FIFO_CNT_W'(fifoCnt);

  // ****************************************
  // flags
  // ****************************************
  logic suspended_q, isrStop_q, lsrIrq_q;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      suspended_q <= 1'b0;
    end else if (!flowOn) begin
      suspended_q <= 1'b0;
    end else if (stopHit) begin
      suspended_q <= 1'b1;
    end else if (resumeHit) begin
      suspended_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      isrStop_q <= 1'b0;
    end else if ((stopHit && cfg.stopIntEn) || specialHit) begin
      isrStop_q <= 1'b1;
    end else if ((resumeHit && suspended_q) || isrRead) begin
      isrStop_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lsrIrq_q <= 1'b0;
    end else if (pushValid && rxReady && pushWord.pe && lsrEv) begin
      lsrIrq_q <= 1'b1;
    end else if (lsrRead) begin
      lsrIrq_q <= 1'b0;
    end
  end

  assign stopFlag = isrStop_q;
  assign lineStatIrq = lsrIrq_q;
  assign irq = isrStop_q || lsrIrq_q;
  assign rxTrigIrq = (level >= ufm_pkg::TRIG_LVL[cfg.trigSel]);

  // ****************************************
  // automatic stop / resume sending
  // ****************************************
  logic txFlowOn, arm_q, xoffSent_q, sendStop, sendResume;
  logic [1:0] wait_q;
  logic [1:0] ctrlPend_q;

  assign txFlowOn = (cfg.txFlow != ufm_pkg::FLOW_OFF);
  assign sendStop = arm_q && charTick && (wait_q == 2'h1);
  assign sendResume = xoffSent_q && !arm_q && (ctrlPend_q == 2'h0)
    && (level <= ufm_pkg::RESUME_LVL[cfg.trigSel]);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      arm_q <= 1'b0;
      wait_q <= 2'h0;
      xoffSent_q <= 1'b0;
    end else if (!txFlowOn) begin
      arm_q <= 1'b0;
      xoffSent_q <= 1'b0;
    end else if (sendStop) begin
      arm_q <= 1'b0;
      xoffSent_q <= 1'b1;
    end else if (sendResume) begin
      xoffSent_q <= 1'b0;
    end else if (arm_q && charTick) begin
      wait_q <= wait_q - 2'h1;
    end else if (!arm_q && !xoffSent_q && (level >= ufm_pkg::TRIG_LVL[cfg.trigSel])) begin
      arm_q <= 1'b1;
      wait_q <= ufm_pkg::XOFF_DELAY_CHARS;
    end
  end

  // ****************************************
  // transmit staging
  // ****************************************
  logic stgValid_q, stgCtrl_q, ctrlStop_q, dirLevel_q, canLoad, txFire;
  logic [7:0] stgData_q;
  logic [7:0] ctrlChar;

  always_comb begin
    case (cfg.txFlow)
      ufm_pkg::FLOW_SET1: ctrlChar = ctrlStop_q ? stop1_q : resume1_q;
      ufm_pkg::FLOW_SET2: ctrlChar = ctrlStop_q ? stop2_q : resume2_q;
      default: begin
        if (ctrlPend_q == 2'h2) begin
          ctrlChar = ctrlStop_q ? stop1_q : resume1_q;
        end else begin
          ctrlChar = ctrlStop_q ? stop2_q : resume2_q;
        end
      end
    endcase
  end

  assign txShValid = stgValid_q && (stgCtrl_q || !suspended_q)
    && (!cfg.autoDirEn || dirLevel_q);
  assign txFire = txShValid && txShReady;
  assign canLoad = !stgValid_q || txFire;
  assign txInReady = canLoad && (ctrlPend_q == 2'h0) && !suspended_q;
  assign txShData = stgData_q;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrlPend_q <= 2'h0;
      ctrlStop_q <= 1'b0;
      stgValid_q <= 1'b0;
      stgCtrl_q <= 1'b0;
      stgData_q <= 8'h00;
    end else begin
      if (sendStop || sendResume) begin
        ctrlPend_q <= (cfg.txFlow == ufm_pkg::FLOW_PAIR) ? 2'h2 : 2'h1;
        ctrlStop_q <= sendStop;
      end else if (canLoad && (ctrlPend_q != 2'h0)) begin
        ctrlPend_q <= ctrlPend_q - 2'h1;
      end
      if (canLoad) begin
        if (ctrlPend_q != 2'h0) begin
          stgValid_q <= 1'b1;
          stgCtrl_q <= 1'b1;
          stgData_q <= ctrlChar;
        end else if (txInValid && !suspended_q) begin
          stgValid_q <= 1'b1;
          stgCtrl_q <= 1'b0;
          stgData_q <= txInData;
        end else begin
          stgValid_q <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // half duplex direction
  // ****************************************
  logic turnWait_q;
  logic [3:0] turnCnt_q;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dirLevel_q <= 1'b0;
      turnWait_q <= 1'b0;
      turnCnt_q <= 4'h0;
    end else if (!cfg.autoDirEn) begin
      dirLevel_q <= 1'b0;
      turnWait_q <= 1'b0;
    end else if (stgValid_q) begin
      dirLevel_q <= 1'b1;
      turnWait_q <= 1'b0;
    end else if (txShDone) begin
      if (cfg.turnDelay == 4'h0) begin
        dirLevel_q <= 1'b0;
      end else begin
        turnWait_q <= 1'b1;
        turnCnt_q <= cfg.turnDelay;
      end
    end else if (turnWait_q && bitTick) begin
      turnCnt_q <= turnCnt_q - 4'h1;
      if (turnCnt_q == 4'h1) begin
        dirLevel_q <= 1'b0;
        turnWait_q <= 1'b0;
      end
    end
  end

  assign rtsN = (cfg.autoDirEn && !cfg.dtrSel) ? dirLevel_q : cfg.rtsSwN;
  assign dtrN = (cfg.autoDirEn && cfg.dtrSel) ? dirLevel_q : cfg.dtrSwN;
  assign txEmptyIrq = !stgValid_q && !txInValid
    && (!cfg.autoDirEn || !txShBusy);

  // ****************************************
  // checks
  // ****************************************
  a_stop_suspends: assert property (@(posedge ref_clk) disable iff (!rst_b)
    stopHit |=> suspended_q && !txInReady) else $error("stop match did not suspend");
  a_stop_irq: assert property (@(posedge ref_clk) disable iff (!rst_b)
    stopHit && cfg.stopIntEn |=> stopFlag && irq) else $error("stop flag missing");
  a_resume_clears: assert property (@(posedge ref_clk) disable iff (!rst_b)
    resumeHit && suspended_q && !specialHit |=> !suspended_q && !stopFlag)
    else $error("resume did not restart");
  a_flow_drop: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rxValid && flowHit && !carry_q |-> !pushValid) else $error("flow char stored");
  a_xoff_delay: assert property (@(posedge ref_clk) disable iff (!rst_b)
    sendStop |=> ctrlPend_q != 2'h0 && xoffSent_q) else $error("stop send lost");
  a_resume_once: assert property (@(posedge ref_clk) disable iff (!rst_b)
    sendResume |=> !xoffSent_q ##1 !sendResume) else $error("resume repeated");
  a_dir_high: assert property (@(posedge ref_clk) disable iff (!rst_b)
    txFire && cfg.autoDirEn |-> (cfg.dtrSel ? dtrN : rtsN))
    else $error("sending while turned");
  a_tsr_empty: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cfg.autoDirEn && txShBusy |-> !txEmptyIrq) else $error("empty while shifting");
  a_md_drop: assert property (@(posedge ref_clk) disable iff (!rst_b)
    mdNormal && !cfg.rxEnableSw && rxValid && !rxParity && !carry_q |-> !pushValid)
    else $error("data kept while disabled");
  a_auto_addr: assert property (@(posedge ref_clk) disable iff (!rst_b)
    mdAuto && rxValid && addrHit |-> pushValid && pushWord.pe ##1 autoEn_q)
    else $error("address match mishandled");

endmodule : ufm_flow_multidrop

// ===== src/ufm_pkg.sv
// constants, enums and carriers for the flow control / multidrop block
// assumes one clock domain and an external rx shifter, tx shifter and baud ticks
package ufm_pkg;

  // ****************************************
  // reset values and counts
  // ****************************************
  localparam logic [7:0] CHAR_RST = 8'h00;
  localparam logic [1:0] XOFF_DELAY_CHARS = 2'h2;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_CNT_W = 5;
  localparam logic [FIFO_CNT_W-1:0] TRIG_LVL [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
  localparam logic [FIFO_CNT_W-1:0] RESUME_LVL [4] = '{5'h00, 5'h01, 5'h04, 5'h08};

  // ****************************************
  // word length masks
  // ****************************************
  localparam logic [7:0] MASK_5B = 8'h1F;
  localparam logic [7:0] MASK_6B = 8'h3F;
  localparam logic [7:0] MASK_7B = 8'h7F;
  localparam logic [7:0] MASK_8B = 8'hFF;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {FLOW_OFF, FLOW_SET1, FLOW_SET2, FLOW_PAIR} ufm_flowsel_e;
  typedef enum logic [1:0] {CH_RESUME1, CH_RESUME2, CH_STOP1, CH_STOP2} ufm_charsel_e;

  typedef struct packed {
    logic pe;
    logic [7:0] data;
  } ufm_rxword_s;

  typedef struct packed {
    ufm_flowsel_e rxFlow;
    ufm_flowsel_e txFlow;
    logic [1:0] wordLen;
    logic [1:0] trigSel;
    logic specialEn;
    logic stopIntEn;
    logic autoDirEn;
    logic [3:0] turnDelay;
    logic multidropEn;
    logic dtrSel;
    logic rxEnableSw;
    logic rtsSwN;
    logic dtrSwN;
  } ufm_cfg_s;

  localparam int RXWORD_W = $bits(ufm_rxword_s);

endpackage : ufm_pkg

// ===== tb/tb.sv
// self-checking bench for the flow control / multidrop block
// assumes the remote model supplies baud ticks and the tx shifter
`timescale 1ns/1ps

module tb;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  ufm_pkg::ufm_cfg_s cfg = '0;
  logic charWrEn = 1'b0;
  ufm_pkg::ufm_charsel_e charWrSel = ufm_pkg::CH_RESUME1;
  logic [7:0] charWrData = 8'h00;
  logic isrRead = 1'b0;
  logic lsrRead = 1'b0;
  logic rxValid = 1'b0;
  logic [7:0] rxData = 8'h00;
  logic rxParity = 1'b0;
  logic rdReady = 1'b0;
  logic txInValid = 1'b0;
  logic [7:0] txInData = 8'h00;
  logic bitTick, charTick, rxReady, rdValid, txInReady, txShValid, txShReady, txShBusy;
  logic txShDone, stopFlag, lineStatIrq, irq, rxTrigIrq, txEmptyIrq, rtsN, dtrN;
  logic [7:0] txShData, lastChar, sentCount;
  ufm_pkg::ufm_rxword_s rdWord;
  int bad_count = 0;
  int samples_checked = 0;

  always #4 ref_clk = ~ref_clk;

  ufm_flow_multidrop DUT (.ref_clk, .rst_b, .cfg, .charWrEn, .charWrSel, .charWrData,
    .isrRead, .lsrRead, .bitTick, .charTick, .rxValid, .rxData, .rxParity, .rxReady,
    .rdValid, .rdReady, .rdWord, .txInValid, .txInReady, .txInData, .txShValid,
    .txShReady, .txShData, .txShBusy, .txShDone, .stopFlag, .lineStatIrq, .irq,
    .rxTrigIrq, .txEmptyIrq, .rtsN, .dtrN);

  ufm_remote_model u_remote (.ref_clk, .rst_b, .bitTick, .charTick, .txShValid,
    .txShReady, .txShData, .txShBusy, .txShDone, .lastChar, .sentCount);

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic waitHi(ref logic s, input int lim);
    int i;
    i = 0;
    while (s !== 1'b1 && i < lim) begin
      cyc(1);
      i++;
    end
    if (s !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, 1'b1);
    end
  endtask : waitHi

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(1);
  endtask : pulse

  task automatic wr(input ufm_pkg::ufm_charsel_e s, input logic [7:0] d);
    charWrSel = s;
    charWrData = d;
    pulse(charWrEn);
  endtask : wr

  task automatic rx(input logic [7:0] d, input logic p);
    rxData = d;
    rxParity = p;
    pulse(rxValid);
  endtask : rx

  task automatic pop(input logic pe, input logic [7:0] d);
    waitHi(rdValid, 20);
    chk(rdWord, {pe, d});
    pulse(rdReady);
  endtask : pop

  task automatic send(input logic [7:0] d);
    txInData = d;
    txInValid = 1'b1;
    waitHi(txInReady, 50);
    cyc(1);
    txInValid = 1'b0;
  endtask : send

  task automatic t_flow_set1();
    cfg.rxFlow = ufm_pkg::FLOW_SET1;
    cfg.stopIntEn = 1'b1;
    wr(ufm_pkg::CH_RESUME1, 8'h11);
    rx(8'h00, 1'b0);
    chk({stopFlag, irq, txInReady, rdValid}, 4'hC);
    wr(ufm_pkg::CH_STOP1, 8'h13);
    rx(8'h41, 1'b0);
    pop(1'b0, 8'h41);
    rx(8'h11, 1'b0);
    chk({stopFlag, txInReady, rdValid}, 3'h2);
    cfg.wordLen = 2'h0;
    rx(8'hF3, 1'b0);
    chk({stopFlag, txInReady}, 2'h2);
    rx(8'hF1, 1'b0);
    chk({stopFlag, txInReady}, 2'h1);
    cfg.wordLen = 2'h3;
    cfg.stopIntEn = 1'b0;
    rx(8'h13, 1'b0);
    chk({stopFlag, txInReady}, 2'h0);
    rx(8'h11, 1'b0);
  endtask : t_flow_set1

  task automatic t_pair();
    cfg.rxFlow = ufm_pkg::FLOW_PAIR;
    wr(ufm_pkg::CH_STOP2, 8'h93);
    wr(ufm_pkg::CH_RESUME2, 8'h91);
    rx(8'h13, 1'b0);
    rx(8'h41, 1'b0);
    pop(1'b0, 8'h13);
    pop(1'b0, 8'h41);
    rx(8'h13, 1'b0);
    rx(8'h93, 1'b0);
    chk({txInReady, rdValid}, 2'h0);
    rx(8'h11, 1'b0);
    rx(8'h91, 1'b0);
    chk({txInReady, rdValid}, 2'h2);
    cfg.rxFlow = ufm_pkg::FLOW_OFF;
  endtask : t_pair

  task automatic t_special();
    cfg.specialEn = 1'b1;
    cfg.stopIntEn = 1'b1;
    wr(ufm_pkg::CH_STOP2, 8'h5A);
    rx(8'h5A, 1'b0);
    chk(stopFlag, 1'b1);
    pop(1'b0, 8'h5A);
    pulse(isrRead);
    chk(stopFlag, 1'b0);
    cfg.specialEn = 1'b0;
  endtask : t_special

  task automatic t_multidrop();
    cfg.multidropEn = 1'b1;
    rx(8'h22, 1'b0);
    chk(rdValid, 1'b0);
    rx(8'h07, 1'b1);
    chk(lineStatIrq, 1'b1);
    pop(1'b1, 8'h07);
    pulse(lsrRead);
    cfg.rxEnableSw = 1'b1;
    rx(8'h44, 1'b0);
    pop(1'b0, 8'h44);
    rx(8'h08, 1'b1);
    chk({lineStatIrq, irq}, 2'h3);
    pop(1'b1, 8'h08);
    pulse(lsrRead);
    cfg.rxEnableSw = 1'b0;
    cfg.specialEn = 1'b1;
    rx(8'h10, 1'b0);
    rx(8'h33, 1'b1);
    chk({rdValid, lineStatIrq}, 2'h0);
    rx(8'h5A, 1'b1);
    chk(lineStatIrq, 1'b1);
    pop(1'b1, 8'h5A);
    rx(8'h20, 1'b0);
    pop(1'b0, 8'h20);
    rx(8'h5A, 1'b1);
    pop(1'b1, 8'h5A);
    rx(8'h33, 1'b1);
    rx(8'h21, 1'b0);
    chk(rdValid, 1'b0);
    pulse(lsrRead);
    cfg.specialEn = 1'b0;
    cfg.multidropEn = 1'b0;
  endtask : t_multidrop

  task automatic t_auto_dir();
    cfg.autoDirEn = 1'b1;
    cfg.turnDelay = 4'h3;
    send(8'h55);
    waitHi(txShValid, 10);
    chk(rtsN, 1'b1);
    cyc(1);
    chk(txEmptyIrq, 1'b0);
    waitHi(txShDone, 100);
    cyc(2);
    chk({rtsN, txEmptyIrq}, 2'h3);
    cyc(16);
    chk(rtsN, 1'b0);
    cfg.dtrSel = 1'b1;
    send(8'h56);
    waitHi(txShValid, 10);
    chk(dtrN, 1'b1);
    waitHi(txShDone, 100);
    cyc(18);
    chk(dtrN, 1'b0);
    cfg.autoDirEn = 1'b0;
  endtask : t_auto_dir

  task automatic t_auto_xoff();
    int i;
    logic [7:0] n;
    cfg.txFlow = ufm_pkg::FLOW_SET1;
    cfg.trigSel = 2'h1;
    n = sentCount;
    for (i = 0; i < 16; i++) begin
      rx(8'h30 + 8'(i), 1'b0);
      if (i == 2) chk(rxTrigIrq, 1'b0);
      if (i == 3) chk(rxTrigIrq, 1'b1);
      if (i == 3) waitHi(charTick, 50);
      if (i == 3) cyc(1);
      if (i == 3) chk(sentCount, n);
      if (i == 3) cyc(90);
      if (i == 3) chk(lastChar, 8'h13);
    end
    chk(rxReady, 1'b0);
    for (i = 0; i < 16; i++) begin
      if (i == 15) chk(lastChar, 8'h13);
      pop(1'b0, 8'h30 + 8'(i));
    end
    cyc(100);
    chk({sentCount, lastChar}, {n + 8'h02, 8'h11});
    cyc(200);
    chk({sentCount, rdValid}, {n + 8'h02, 1'b0});
  endtask : t_auto_xoff

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    cfg.wordLen = 2'h3;
    cyc(8);
    rst_b = 1'b1;
    cyc(1);
    chk({stopFlag, lineStatIrq, rdValid, txShValid}, 4'h0);
    t_flow_set1();
    t_pair();
    t_special();
    t_multidrop();
    t_auto_dir();
    t_auto_xoff();
    end_sim();
  end

  initial begin
    #100000;
    bad_count++;
    end_sim();
  end
endmodule : tb

// ===== tb/ufm_remote_model.sv
// remote station model: baud tick source and transmit shifter
// assumes one character per txShValid/txShReady handshake on ref_clk
`timescale 1ns/1ps

module ufm_remote_model #(
  parameter int BIT_CYC = 4,
  parameter int CHAR_CYC = 40
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // baud ticks
  output logic bitTick,
  output logic charTick,
  // tx shifter
  input wire logic txShValid,
  output logic txShReady,
  input wire logic [7:0] txShData,
  output logic txShBusy,
  output logic txShDone,
  // log of characters put on the line
  output logic [7:0] lastChar,
  output logic [7:0] sentCount
);
  logic [7:0] tick_q;
  logic [7:0] left_q;

  assign bitTick = (tick_q % 8'(BIT_CYC)) == 8'h00;
  assign charTick = tick_q == 8'h00;
  assign txShBusy = left_q != 8'h00;
  assign txShReady = !txShBusy;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_q <= 8'h00;
    end else begin
      tick_q <= (tick_q == 8'(CHAR_CYC - 1)) ? 8'h00 : tick_q + 8'h01;
    end
  end

  // shifter takes a full character time; done marks the final stop bit
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      left_q <= 8'h00;
      txShDone <= 1'b0;
      lastChar <= 8'h00;
      sentCount <= 8'h00;
    end else begin
      txShDone <= left_q == 8'h01;
      if (txShValid && txShReady) begin
        left_q <= 8'(CHAR_CYC);
        lastChar <= txShData;
        sentCount <= sentCount + 8'h01;
      end else if (txShBusy) begin
        left_q <= left_q - 8'h01;
      end
    end
  end
endmodule : ufm_remote_model
